// ---- smd_regs.svh ----
// Constants for the shift and multiply-accumulate datapath slice.
// Assumes inclusion by bare name from the same folder.
`ifndef SMD_REGS_SVH
`define SMD_REGS_SVH
`define SMD_ADDR_MODE        4'h0
`define SMD_ADDR_FLAGS       4'h1
`define SMD_ADDR_ACC_A2      4'h2
`define SMD_ADDR_ACC_A1      4'h3
`define SMD_ADDR_ACC_A0      4'h4
`define SMD_ADDR_ACC_B2      4'h5
`define SMD_ADDR_ACC_B1      4'h6
`define SMD_ADDR_ACC_B0      4'h7
`define SMD_ADDR_X0          4'h8
`define SMD_ADDR_Y0          4'h9
`define SMD_ADDR_Y1          4'ha
`define SMD_ADDR_STATUS      4'hb
`define SMD_ADDR_OPMODE      4'hc
`define SMD_MODE_RESET       8'h00
`define SMD_FLAGS_RESET      8'h00
`define SMD_OPMODE_RESET     8'h00
`define SMD_FLAG_C           0
`define SMD_FLAG_V           1
`define SMD_FLAG_Z           2
`define SMD_FLAG_N           3
`define SMD_FLAG_U           4
`define SMD_FLAG_E           5
`define SMD_FLAG_L           6
`define SMD_FLAG_SZ          7
`define SMD_MODE_SAT         5
`define SMD_OPMODE_DEXEC     0
`define SMD_OP_CYCLES        2
`define SMD_CNT_BITS         4
`define SMD_ACC_MSB          35
`define SMD_WORD_SPLIT       31
`endif

// ---- smd_pkg.sv ----
// Types shared by the datapath slice and its operation unit.
// Assumes smd_regs.svh is compiled in the same library.
package smd_pkg;
   typedef enum logic [1:0] {
      SMD_OP_SHIFT_ACC = 2'h0,
      SMD_OP_SHIFT_RR  = 2'h1,
      SMD_OP_MAC       = 2'h2
   } smd_op_t;
   typedef enum logic [2:0] {
      SMD_PAIR_Y1_X0 = 3'h0,
      SMD_PAIR_Y0_X0 = 3'h1,
      SMD_PAIR_Y1_Y0 = 3'h2,
      SMD_PAIR_Y0_Y0 = 3'h3,
      SMD_PAIR_A1_Y0 = 3'h4,
      SMD_PAIR_B1_Y1 = 3'h5
   } smd_pair_t;
   typedef enum logic [2:0] {
      SMD_DST_A  = 3'h0,
      SMD_DST_B  = 3'h1,
      SMD_DST_X0 = 3'h2,
      SMD_DST_Y0 = 3'h3,
      SMD_DST_Y1 = 3'h4
   } smd_dst_t;
   typedef enum logic [2:0] {
      SMD_ST_IDLE = 3'b001,
      SMD_ST_EXEC = 3'b010,
      SMD_ST_MOVE = 3'b100
   } smd_state_t;
endpackage : smd_pkg

// ---- smd_alu_if.sv ----
// Operands and result between the sequencer and the arithmetic unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface smd_alu_if;
   smd_pkg::smd_op_t op;
   logic             negate;
   logic [15:0]      src1;
   logic [15:0]      src2;
   logic [35:0]      dst_val;
   logic             dst_is_acc;
   logic [35:0]      result;
   logic             overflow;
   modport seq (output op, output negate, output src1, output src2, output dst_val, output dst_is_acc,
                input result, input overflow);
   modport alu (input op, input negate, input src1, input src2, input dst_val, input dst_is_acc,
                output result, output overflow);
endinterface : smd_alu_if

// ---- smd_alu.sv ----
// Combinational arithmetic for shift-accumulate, multi-bit shift and MAC.
// Assumes operands stay stable while the sequencer samples the result.
`timescale 1ns/1ns
`include "smd_regs.svh"
module smd_alu (
   smd_alu_if.alu bus
);
   wire [3:0]  cnt      = bus.src2[`SMD_CNT_BITS-1:0];
   wire [35:0] sa_wide  = {4'h0, bus.src1, 16'h0000};
   wire [35:0] sa_shift = sa_wide >> cnt;
   wire [35:0] sa_sum   = bus.dst_val + sa_shift;
   wire [15:0] rr_word  = bus.src1 >> cnt;
   wire [35:0] rr_res   = bus.dst_is_acc ? {4'h0, rr_word, 16'h0000}
                                         : {20'h00000, rr_word};
   wire signed [31:0] prod_raw = $signed(bus.src1) * $signed(bus.src2);
   wire [31:0] prod_frac = {prod_raw[30:0], 1'b0};
   wire [35:0] prod_ext  = {{4{prod_frac[31]}}, prod_frac};
   wire [35:0] mac_res   = bus.negate ? bus.dst_val - prod_ext
                                      : bus.dst_val + prod_ext;
   wire        a_s = bus.dst_val[`SMD_ACC_MSB];
   wire        p_s = prod_ext[`SMD_ACC_MSB] ^ bus.negate;
   wire        r_s = mac_res[`SMD_ACC_MSB];
   wire        mac_ovf = (a_s == p_s) && (r_s != a_s) && (prod_ext != 36'h0);
   always_comb begin
      case (bus.op)
         smd_pkg::SMD_OP_SHIFT_ACC: bus.result = sa_sum;
         smd_pkg::SMD_OP_SHIFT_RR:  bus.result = rr_res;
         smd_pkg::SMD_OP_MAC:       bus.result = mac_res;
         default:                   bus.result = 36'h0;
      endcase
   end
   assign bus.overflow = (bus.op == smd_pkg::SMD_OP_MAC) && mac_ovf;
endmodule : smd_alu

// ---- smd_datapath.sv ----
// Top of the shift and multiply-accumulate datapath slice: register file,
// two-cycle sequencer, flag update and parallel dual-read address update.
// Assumes callers start an operation only while busy is low.
`timescale 1ns/1ns
`include "smd_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Shift-accumulate shifts first operand right and adds into chosen accumulator
// - Count is low four bits of second operand; operand placed at bits 31:16
// - Shift-accumulate: negative from bit 35, zero when whole result zero
// - Shift-accumulate takes two cycles, six operand pairs, A or B destination
// - Multi-bit shift moves source right by four-bit count into destination
// - Accumulator target: upper word shifted, lower cleared, extension zero
// - Multi-bit shift never saturates whatever the saturation enable bit
// - Multi-bit shift: negative from bit 31 for an accumulator or bit 15 for a register, zero when result zero
// - Multi-bit shift takes two cycles, any 16-bit register or accumulator
// - MAC multiplies signed fractions, adds or subtracts 32-bit product
// - MAC sources: accumulator upper word or X0, Y0, Y1 in six pairs
// - Product sign-extended to 36 bits before accumulate
// - 16-bit destination sign-extended with zero low word; high word stored
// - Limit flag set on parallel move limiting or result overflow
// - Extension flag when extension in use; overflow flag on overflow
// - MAC: zero flag on zero result, negative from result MSB
// - Dual reads load operand registers and post-increment both address registers
// - MAC takes two cycles plus parallel move cycles, one program word
module smd_datapath #(
   parameter int MOVE_CYCLES = 1
) (
   input  wire logic                core_clk,
   input  wire logic                reset,
   input  wire logic [3:0]          reg_addr,
   input  wire logic [15:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output      logic [15:0]         reg_rdata,
   input  wire logic                op_start,
   input  wire smd_pkg::smd_op_t    op_code,
   input  wire smd_pkg::smd_pair_t  op_pair,
   input  wire smd_pkg::smd_dst_t   op_dst,
   input  wire logic                op_negate,
   input  wire logic                op_move,
   input  wire logic                op_move_limited,
   input  wire logic                op_dual_read,
   input  wire logic                dual_sel_r1,
   input  wire logic                dual_dst_y1,
   input  wire logic [15:0]         dual_data1,
   input  wire logic [15:0]         dual_data2,
   output      logic                busy,
   output      logic                op_done,
   output      logic [15:0]         addr_first_q,
   output      logic [15:0]         addr_second_q,
   output      logic                dual_illegal
);
   ////////////////////////////////////////////////////////////////////////////
   // State
   smd_pkg::smd_state_t state_q, state_d;
   logic [1:0]  cyc_q;
   logic [7:0]  mode_q;
   logic [7:0]  flags_q;
   logic [7:0]  opmode_q;
   logic [35:0] acc_a_q, acc_b_q;
   logic [15:0] x0_q, y0_q, y1_q;
   logic [15:0] r0_q, r1_q, r3_q;
   smd_pkg::smd_op_t   op_q;
   smd_pkg::smd_pair_t pair_q;
   smd_pkg::smd_dst_t  dst_q;
   logic        neg_q, move_q, lim_q, dual_q, sel_r1_q, dy1_q;
   logic [15:0] dd1_q, dd2_q;
   logic        done_q;

   smd_alu_if alu_bus ();
   smd_alu u_alu (.bus(alu_bus));

   ////////////////////////////////////////////////////////////////////////////
   // Operand selection
   function automatic logic [15:0] pick_src1(input smd_pkg::smd_pair_t p, input logic [15:0] y1,
                                             input logic [15:0] y0, input logic [15:0] a1,
                                             input logic [15:0] b1);
      case (p)
         smd_pkg::SMD_PAIR_Y1_X0, smd_pkg::SMD_PAIR_Y1_Y0: pick_src1 = y1;
         smd_pkg::SMD_PAIR_Y0_X0, smd_pkg::SMD_PAIR_Y0_Y0: pick_src1 = y0;
         smd_pkg::SMD_PAIR_A1_Y0: pick_src1 = a1;
         smd_pkg::SMD_PAIR_B1_Y1: pick_src1 = b1;
         default: pick_src1 = 16'h0000;
      endcase
   endfunction : pick_src1

   function automatic logic [15:0] pick_src2(input smd_pkg::smd_pair_t p, input logic [15:0] x0,
                                             input logic [15:0] y0, input logic [15:0] y1);
      case (p)
         smd_pkg::SMD_PAIR_Y1_X0, smd_pkg::SMD_PAIR_Y0_X0: pick_src2 = x0;
         smd_pkg::SMD_PAIR_Y1_Y0, smd_pkg::SMD_PAIR_Y0_Y0, smd_pkg::SMD_PAIR_A1_Y0: pick_src2 = y0;
         smd_pkg::SMD_PAIR_B1_Y1: pick_src2 = y1;
         default: pick_src2 = 16'h0000;
      endcase
   endfunction : pick_src2

   wire [15:0] a1 = acc_a_q[31:16];
   wire [15:0] b1 = acc_b_q[31:16];
   wire [15:0] s1 = pick_src1(pair_q, y1_q, y0_q, a1, b1);
   wire [15:0] s2 = pick_src2(pair_q, x0_q, y0_q, y1_q);
   wire        dst_acc = (dst_q == smd_pkg::SMD_DST_A) || (dst_q == smd_pkg::SMD_DST_B);
   wire [15:0] dst_word = (dst_q == smd_pkg::SMD_DST_X0) ? x0_q :
                          (dst_q == smd_pkg::SMD_DST_Y0) ? y0_q : y1_q;
   wire [35:0] dst_acc_val = (dst_q == smd_pkg::SMD_DST_B) ? acc_b_q : acc_a_q;
   wire [35:0] dst_full = dst_acc ? dst_acc_val
                                  : {{4{dst_word[15]}}, dst_word, 16'h0000};

   assign alu_bus.op         = op_q;
   assign alu_bus.negate     = neg_q && (op_q == smd_pkg::SMD_OP_MAC);
   assign alu_bus.src1       = s1;
   assign alu_bus.src2       = s2;
   assign alu_bus.dst_val    = dst_full;
   assign alu_bus.dst_is_acc = dst_acc;

   ////////////////////////////////////////////////////////////////////////////
   // Flag computation
   wire [35:0] res     = alu_bus.result;
   wire [15:0] res_hi  = res[31:16];
   wire        is_rr   = (op_q == smd_pkg::SMD_OP_SHIFT_RR);
   wire        is_mac  = (op_q == smd_pkg::SMD_OP_MAC);
   wire        neg_acc = res[`SMD_ACC_MSB];
   wire        neg_f   = dst_acc ? (is_rr ? res[`SMD_WORD_SPLIT] : neg_acc)
                                 : (is_rr ? res[15] : res_hi[15]);
   wire        zero_f  = dst_acc ? (res == 36'h0)
                                 : (is_rr ? (res[15:0] == 16'h0000) : (res_hi == 16'h0000));
   wire        ext_f   = !((res[35:31] == 5'h00) || (res[35:31] == 5'h1f));
   wire        unn_f   = (res[31] == res[30]);
   wire        ovf     = alu_bus.overflow;

   logic [7:0] flags_new;
   always_comb begin
      flags_new = flags_q;
      flags_new[`SMD_FLAG_N] = neg_f;
      flags_new[`SMD_FLAG_Z] = zero_f;
      if (is_mac) begin
         flags_new[`SMD_FLAG_E] = ext_f;
         flags_new[`SMD_FLAG_U] = unn_f;
         flags_new[`SMD_FLAG_V] = ovf;
         flags_new[`SMD_FLAG_L] = flags_q[`SMD_FLAG_L] | ovf | (move_q & lim_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: one execute pass of two cycles, then optional move cycles
   wire exec_last = (cyc_q == 2'(`SMD_OP_CYCLES - 1));
   wire move_last = (cyc_q == 2'(MOVE_CYCLES - 1));
   wire writeback = (state_q == smd_pkg::SMD_ST_EXEC) && exec_last;
   wire start_ok  = (state_q == smd_pkg::SMD_ST_IDLE) && op_start;
   // Dual reads are dropped while executing from data memory
   wire dual_ok   = dual_q && is_mac && !opmode_q[`SMD_OPMODE_DEXEC];

   always_comb begin
      case (state_q)
         smd_pkg::SMD_ST_IDLE: state_d = start_ok ? smd_pkg::SMD_ST_EXEC : smd_pkg::SMD_ST_IDLE;
         smd_pkg::SMD_ST_EXEC: state_d = !exec_last ? smd_pkg::SMD_ST_EXEC :
                                         (is_mac && move_q) ? smd_pkg::SMD_ST_MOVE
                                                            : smd_pkg::SMD_ST_IDLE;
         smd_pkg::SMD_ST_MOVE: state_d = move_last ? smd_pkg::SMD_ST_IDLE : smd_pkg::SMD_ST_MOVE;
         default:              state_d = smd_pkg::SMD_ST_IDLE;
      endcase
   end

   assign busy         = (state_q != smd_pkg::SMD_ST_IDLE);
   assign op_done      = done_q;
   assign dual_illegal = dual_q && opmode_q[`SMD_OPMODE_DEXEC] && busy;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= smd_pkg::SMD_ST_IDLE;
         cyc_q   <= 2'h0;
         done_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cyc_q   <= (state_d != state_q || state_q == smd_pkg::SMD_ST_IDLE) ? 2'h0 : cyc_q + 2'h1;
         done_q  <= busy && (state_d == smd_pkg::SMD_ST_IDLE);
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         op_q <= smd_pkg::SMD_OP_SHIFT_ACC;
         pair_q <= smd_pkg::SMD_PAIR_Y1_X0;
         dst_q <= smd_pkg::SMD_DST_A;
         {neg_q, move_q, lim_q, dual_q, sel_r1_q, dy1_q} <= 6'h00;
         dd1_q <= 16'h0000;
         dd2_q <= 16'h0000;
      end else if (start_ok) begin
         op_q <= op_code;
         pair_q <= op_pair;
         // Shift-accumulate only lands in A or B
         dst_q <= (op_code == smd_pkg::SMD_OP_SHIFT_ACC && op_dst != smd_pkg::SMD_DST_B)
                  ? smd_pkg::SMD_DST_A : op_dst;
         {neg_q, move_q, lim_q, dual_q, sel_r1_q, dy1_q} <=
            {op_negate, op_move, op_move_limited, op_dual_read, dual_sel_r1, dual_dst_y1};
         dd1_q <= dual_data1;
         dd2_q <= dual_data2;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file and write-back
   wire dw = writeback && dual_ok;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         mode_q   <= `SMD_MODE_RESET;
         flags_q  <= `SMD_FLAGS_RESET;
         opmode_q <= `SMD_OPMODE_RESET;
         acc_a_q  <= 36'h0;
         acc_b_q  <= 36'h0;
         x0_q     <= 16'h0000;
         y0_q     <= 16'h0000;
         y1_q     <= 16'h0000;
      end else if (writeback) begin
         flags_q <= flags_new;
         case (dst_q)
            smd_pkg::SMD_DST_A:  acc_a_q <= res;
            smd_pkg::SMD_DST_B:  acc_b_q <= res;
            smd_pkg::SMD_DST_X0: x0_q <= is_rr ? res[15:0] : res_hi;
            smd_pkg::SMD_DST_Y0: y0_q <= is_rr ? res[15:0] : res_hi;
            smd_pkg::SMD_DST_Y1: y1_q <= is_rr ? res[15:0] : res_hi;
            default: ;
         endcase
         // Memory loads win over the ALU write; program keeps them apart
         if (dw) begin
            if (dy1_q)
               y1_q <= dd1_q;
            else
               y0_q <= dd1_q;
            x0_q <= dd2_q;
         end
      end else if (reg_wr && !busy) begin
         case (reg_addr)
            `SMD_ADDR_MODE:   mode_q   <= reg_wdata[7:0];
            `SMD_ADDR_FLAGS:  flags_q  <= reg_wdata[7:0];
            `SMD_ADDR_OPMODE: opmode_q <= reg_wdata[7:0];
            `SMD_ADDR_ACC_A2: acc_a_q[35:32] <= reg_wdata[3:0];
            `SMD_ADDR_ACC_A1: acc_a_q[31:16] <= reg_wdata;
            `SMD_ADDR_ACC_A0: acc_a_q[15:0]  <= reg_wdata;
            `SMD_ADDR_ACC_B2: acc_b_q[35:32] <= reg_wdata[3:0];
            `SMD_ADDR_ACC_B1: acc_b_q[31:16] <= reg_wdata;
            `SMD_ADDR_ACC_B0: acc_b_q[15:0]  <= reg_wdata;
            `SMD_ADDR_X0:     x0_q <= reg_wdata;
            `SMD_ADDR_Y0:     y0_q <= reg_wdata;
            `SMD_ADDR_Y1:     y1_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address registers for dual parallel reads
   always_ff @(posedge core_clk) begin
      if (reset) begin
         r0_q <= 16'h0000;
         r1_q <= 16'h0000;
         r3_q <= 16'h0000;
      end else if (dw) begin
         if (sel_r1_q)
            r1_q <= r1_q + 16'h0001;
         else
            r0_q <= r0_q + 16'h0001;
         r3_q <= r3_q + 16'h0001;
      end
   end

   assign addr_first_q  = sel_r1_q ? r1_q : r0_q;
   assign addr_second_q = r3_q;

   ////////////////////////////////////////////////////////////////////////////
   // Register read port, data one cycle after the strobe
   logic [15:0] rd_mux;
   always_comb begin
      case (reg_addr)
         `SMD_ADDR_MODE:   rd_mux = {8'h00, mode_q};
         `SMD_ADDR_FLAGS:  rd_mux = {8'h00, flags_q};
         `SMD_ADDR_OPMODE: rd_mux = {8'h00, opmode_q};
         `SMD_ADDR_ACC_A2: rd_mux = {12'h000, acc_a_q[35:32]};
         `SMD_ADDR_ACC_A1: rd_mux = acc_a_q[31:16];
         `SMD_ADDR_ACC_A0: rd_mux = acc_a_q[15:0];
         `SMD_ADDR_ACC_B2: rd_mux = {12'h000, acc_b_q[35:32]};
         `SMD_ADDR_ACC_B1: rd_mux = acc_b_q[31:16];
         `SMD_ADDR_ACC_B0: rd_mux = acc_b_q[15:0];
         `SMD_ADDR_X0:     rd_mux = x0_q;
         `SMD_ADDR_Y0:     rd_mux = y0_q;
         `SMD_ADDR_Y1:     rd_mux = y1_q;
         `SMD_ADDR_STATUS: rd_mux = {13'h0000, state_q};
         default:          rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset)
         reg_rdata <= 16'h0000;
      else
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
   end
endmodule : smd_datapath

// ---- smd_datapath_checker.sv ----
// Concurrent checks on the top ports of the datapath slice.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module smd_datapath_checker #(
   parameter int MOVE_CYCLES = 1
) (
   input wire logic             core_clk,
   input wire logic             reset,
   input wire logic             reg_rd,
   input wire logic [15:0]      reg_rdata,
   input wire logic             op_start,
   input wire smd_pkg::smd_op_t op_code,
   input wire logic             op_move,
   input wire logic             busy,
   input wire logic             op_done,
   input wire logic [15:0]      addr_second_q,
   input wire logic             dual_illegal
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   logic [7:0] len_q;
   logic [7:0] exp_q;
   // Busy length seen and busy length owed by the last accepted start
   always_ff @(posedge core_clk) begin
      if (reset) begin
         len_q <= 8'h00;
         exp_q <= 8'h00;
      end else begin
         len_q <= busy ? len_q + 8'h01 : 8'h00;
         if (op_start && !busy) begin
            exp_q <= (op_code == smd_pkg::SMD_OP_MAC && op_move) ? 8'(2 + MOVE_CYCLES) : 8'h02;
         end
      end
   end
   sequence op_taken_s;
      op_start && !busy;
   endsequence
   sequence op_finish_s;
      !busy ##0 op_done;
   endsequence
   busy_two_min_a:
   assert property (op_taken_s |=> busy [*2]) else $error("busy shorter than two cycles");
   op_length_a:
   assert property ($fell(busy) |-> len_q == exp_q) else $error("operation length wrong");
   done_after_busy_a:
   assert property ($fell(busy) |-> op_finish_s) else $error("no done after busy");
   done_single_a:
   assert property (op_done |=> !op_done) else $error("done longer than one cycle");
   done_cause_a:
   assert property (op_done |-> $past(busy)) else $error("done without busy");
   read_idle_zero_a:
   assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside window");
   addr_step_a:
   assert property ($changed(addr_second_q) |-> addr_second_q == $past(addr_second_q) + 16'h0001 && $past(busy))
      else $error("second address not stepped by one");
   blocked_addr_a:
   assert property (dual_illegal |-> busy ##1 $stable(addr_second_q)) else $error("blocked dual read moved address");
endmodule : smd_datapath_checker
bind smd_datapath smd_datapath_checker #(.MOVE_CYCLES(MOVE_CYCLES)) u_checker (
   .core_clk(core_clk), .reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_start(op_start),
   .op_code(op_code), .op_move(op_move), .busy(busy), .op_done(op_done), .addr_second_q(addr_second_q),
   .dual_illegal(dual_illegal));

// ---- tb_shift_and_mac_datapath.sv ----
// Self-checking bench for the datapath slice: register tasks and operation runs.
// Assumes the package, interface, design and checker files are compiled first.
`timescale 1ns/1ns
`include "smd_regs.svh"
module tb_shift_and_mac_datapath;
   logic                core_clk = 1'b0;
   logic                reset = 1'b1;
   logic [3:0]          reg_addr = 4'h0;
   logic [15:0]         reg_wdata = 16'h0000;
   logic                reg_wr = 1'b0;
   logic                reg_rd = 1'b0;
   logic [15:0]         reg_rdata;
   logic                op_start = 1'b0;
   smd_pkg::smd_op_t    op_code = smd_pkg::SMD_OP_SHIFT_ACC;
   smd_pkg::smd_pair_t  op_pair = smd_pkg::SMD_PAIR_Y1_X0;
   smd_pkg::smd_dst_t   op_dst = smd_pkg::SMD_DST_A;
   logic                op_negate = 1'b0;
   logic                op_move = 1'b0;
   logic                op_move_limited = 1'b0;
   logic                op_dual_read = 1'b0;
   logic                dual_sel_r1 = 1'b0;
   logic                dual_dst_y1 = 1'b0;
   logic [15:0]         dual_data1 = 16'h0000;
   logic [15:0]         dual_data2 = 16'h0000;
   logic                busy;
   logic                op_done;
   logic [15:0]         addr_first_q;
   logic [15:0]         addr_second_q;
   logic                dual_illegal;
   logic                seen_illegal = 1'b0;
   int                  n_mismatch = 0;
   int                  samples_checked = 0;
   logic [15:0]         pexp [6] = '{16'h0080, 16'h0001, 16'h0040, 16'h0000, 16'h0200, 16'h0200};
   smd_datapath #(.MOVE_CYCLES(2)) dut (
      .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .op_start, .op_code,
      .op_pair, .op_dst, .op_negate, .op_move, .op_move_limited, .op_dual_read, .dual_sel_r1, .dual_dst_y1,
      .dual_data1, .dual_data2, .busy, .op_done, .addr_first_q, .addr_second_q, .dual_illegal);
   always #2 core_clk = ~core_clk;
   // Remembers any cycle with a refused dual read
   always @(posedge core_clk) begin
      if (dual_illegal === 1'b1) begin
         seen_illegal <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e, input string what);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(what, reg_rdata & m, e);
   endtask : rd
   task automatic acc_wr(input logic [3:0] b, input logic [35:0] v);
      wr(b, {12'h000, v[35:32]});
      wr(b + 4'h1, v[31:16]);
      wr(b + 4'h2, v[15:0]);
   endtask : acc_wr
   task automatic acc_rd(input logic [3:0] b, input logic [35:0] v, input string what);
      rd(b, 16'h000f, {12'h000, v[35:32]}, what);
      rd(b + 4'h1, 16'hffff, v[31:16], what);
      rd(b + 4'h2, 16'hffff, v[15:0], what);
   endtask : acc_rd
   // Code 0 shift-accumulate, 1 multi-bit shift, 2 multiply-accumulate
   task automatic run(input logic [1:0] c, input logic [2:0] p, input logic [2:0] d, input logic neg);
      int n;
      @(posedge core_clk);
      op_code   <= smd_pkg::smd_op_t'(c);
      op_pair   <= smd_pkg::smd_pair_t'(p);
      op_dst    <= smd_pkg::smd_dst_t'(d);
      op_negate <= neg;
      op_start  <= 1'b1;
      @(posedge core_clk);
      op_start <= 1'b0;
      n = 0;
      #1;
      while (op_done !== 1'b1 && n < 20) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk("op_done", {15'h0000, op_done}, 16'h0001);
   endtask : run
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge core_clk);
      n_mismatch++;
      complete_run();
   end
   initial begin
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      wr(4'he, 16'hffff);
      for (int a = 0; a < 16; a++) begin
         rd(4'(a), 16'hffff, (a == 11) ? 16'h0001 : 16'h0000, "reset value");
      end
      wr(`SMD_ADDR_X0, 16'h0004);
      wr(`SMD_ADDR_Y1, 16'hc003);
      acc_wr(`SMD_ADDR_ACC_A2, 36'h0_0000_0099);
      run(2'h0, 3'h0, 3'h0, 1'b0);
      acc_rd(`SMD_ADDR_ACC_A2, 36'h0_0c00_3099, "shift acc A");
      rd(`SMD_ADDR_FLAGS, 16'h000c, 16'h0000, "shift acc flags");
      wr(`SMD_ADDR_Y0, 16'h8000);
      acc_wr(`SMD_ADDR_ACC_B2, 36'h8_0000_0000);
      run(2'h0, 3'h3, 3'h1, 1'b0);
      acc_rd(`SMD_ADDR_ACC_B2, 36'h8_8000_0000, "zero count B");
      rd(`SMD_ADDR_FLAGS, 16'h000c, 16'h0008, "shift acc sign");
      wr(`SMD_ADDR_MODE, 16'h0020);
      wr(`SMD_ADDR_Y1, 16'haaaa);
      acc_wr(`SMD_ADDR_ACC_A2, 36'hf_ffff_ffff);
      run(2'h1, 3'h0, 3'h0, 1'b0);
      acc_rd(`SMD_ADDR_ACC_A2, 36'h0_0aaa_0000, "shift A");
      rd(`SMD_ADDR_FLAGS, 16'h000c, 16'h0000, "shift flags");
      run(2'h1, 3'h3, 3'h0, 1'b0);
      acc_rd(`SMD_ADDR_ACC_A2, 36'h0_8000_0000, "unsaturated A");
      rd(`SMD_ADDR_FLAGS, 16'h000c, 16'h0008, "shift sign");
      wr(`SMD_ADDR_MODE, 16'h0000);
      wr(`SMD_ADDR_X0, 16'h000f);
      wr(`SMD_ADDR_Y1, 16'h0001);
      run(2'h1, 3'h0, 3'h3, 1'b0);
      rd(`SMD_ADDR_Y0, 16'hffff, 16'h0000, "shift to Y0");
      rd(`SMD_ADDR_FLAGS, 16'h000c, 16'h0004, "shift zero");
      wr(`SMD_ADDR_X0, 16'h0001);
      wr(`SMD_ADDR_Y0, 16'h0002);
      wr(`SMD_ADDR_Y1, 16'h0100);
      wr(`SMD_ADDR_ACC_A1, 16'h0800);
      for (int i = 0; i < 6; i++) begin
         run(2'h1, 3'(i), 3'h1, 1'b0);
         rd(`SMD_ADDR_ACC_B1, 16'hffff, pexp[i], "pair result");
      end
      wr(`SMD_ADDR_X0, 16'h4000);
      wr(`SMD_ADDR_Y1, 16'h0aa0);
      acc_wr(`SMD_ADDR_ACC_A2, 36'h0_0003_0003);
      op_dual_read <= 1'b1;
      dual_sel_r1  <= 1'b1;
      dual_dst_y1  <= 1'b1;
      dual_data1   <= 16'h1234;
      dual_data2   <= 16'h5678;
      run(2'h2, 3'h0, 3'h0, 1'b0);
      acc_rd(`SMD_ADDR_ACC_A2, 36'h0_0553_0003, "mac A");
      rd(`SMD_ADDR_FLAGS, 16'h006e, 16'h0000, "mac flags");
      rd(`SMD_ADDR_Y1, 16'hffff, 16'h1234, "dual load Y1");
      rd(`SMD_ADDR_X0, 16'hffff, 16'h5678, "dual load X0");
      chk("first address", addr_first_q, 16'h0001);
      chk("second address", addr_second_q, 16'h0001);
      chk("legal dual read", {15'h0000, seen_illegal}, 16'h0000);
      wr(`SMD_ADDR_OPMODE, 16'h0001);
      dual_data1 <= 16'h9999;
      run(2'h2, 3'h0, 3'h0, 1'b0);
      rd(`SMD_ADDR_Y1, 16'hffff, 16'h1234, "blocked load");
      chk("blocked address", addr_second_q, 16'h0001);
      chk("refused dual read", {15'h0000, seen_illegal}, 16'h0001);
      wr(`SMD_ADDR_OPMODE, 16'h0000);
      op_dual_read <= 1'b0;
      wr(`SMD_ADDR_X0, 16'h4000);
      wr(`SMD_ADDR_Y1, 16'hc000);
      acc_wr(`SMD_ADDR_ACC_A2, 36'h0_0003_8000);
      run(2'h2, 3'h0, 3'h0, 1'b1);
      acc_rd(`SMD_ADDR_ACC_A2, 36'h0_2003_8000, "negated mac");
      wr(`SMD_ADDR_Y0, 16'h4000);
      run(2'h2, 3'h3, 3'h4, 1'b0);
      rd(`SMD_ADDR_Y1, 16'hffff, 16'he000, "mac to Y1");
      acc_wr(`SMD_ADDR_ACC_A2, 36'h7_ffff_ffff);
      op_move <= 1'b1;
      run(2'h2, 3'h3, 3'h0, 1'b0);
      rd(`SMD_ADDR_FLAGS, 16'h006e, 16'h006a, "overflow flags");
      wr(`SMD_ADDR_FLAGS, 16'h0000);
      op_move_limited <= 1'b1;
      acc_wr(`SMD_ADDR_ACC_A2, 36'h0_0000_0000);
      run(2'h2, 3'h3, 3'h0, 1'b0);
      rd(`SMD_ADDR_FLAGS, 16'h0042, 16'h0040, "limited move");
      complete_run();
   end
endmodule : tb_shift_and_mac_datapath
